// file: mpc_checker.sv
/* Port checker for the management serial controller.
   Assumes a bind onto mpc_mgmt_ctrl with ports matched by name. */
`timescale 1ns/1ps
module mpc_checker
    import mpc_pkg::*;
(
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic        mgmt_serial_clock, mdio_out, mdio_oe, irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] sh_div, per;
    logic        en_sh, pre_sh, ok;
    wire         wr_c = psel && penable && pwrite && paddr == OFS_CONTROL;
    wire         rd_s = psel && !penable && !pwrite;
    wire         rd_a = psel && penable && !pwrite;
    // Control shadow; period check skips a period after any disturbance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sh_div, en_sh, pre_sh, ok, per} <= {CLKDIV_RESET, 19'h0_0000};
        end else begin
            if (wr_c) begin
                {sh_div, en_sh, pre_sh} <= {pwdata[15:0], pwdata[30], pwdata[20]};
            end
            ok  <= !wr_c && !$fell(mdio_oe) && (ok || $rose(mgmt_serial_clock));
            per <= $rose(mgmt_serial_clock) ? 16'h0000 : per + 16'h0001;
        end
    end
    property p_hi; rd_s && paddr == OFS_CONTROL |=> prdata[28:24] == HIGHEST_CHANNEL; endproperty
    a_hi: assert property (p_hi) else $error("channel field wrong");
    property p_per; ok && $rose(mgmt_serial_clock) |-> per == sh_div; endproperty
    a_per: assert property (p_per) else $error("serial period wrong");
    property p_stop; sh_div == 16'h0000 && $past(sh_div) == 16'h0000 |-> !$rose(mgmt_serial_clock); endproperty
    a_stop: assert property (p_stop) else $error("clock runs at zero");
    property p_pre; $rose(mdio_oe) |-> mdio_out == !pre_sh; endproperty
    a_pre: assert property (p_pre) else $error("frame opening wrong");
    property p_en; $rose(mdio_oe) |-> en_sh || $past(en_sh, 2); endproperty
    a_en: assert property (p_en) else $error("frame while disabled");
    property p_drv; mdio_oe && $changed(mdio_out) |-> !mgmt_serial_clock; endproperty
    a_drv: assert property (p_drv) else $error("data moved while high");
    property p_irl; rd_a && paddr == OFS_LINK_GATED && prdata[1:0] != 2'b00 |-> irq; endproperty
    a_irl: assert property (p_irl) else $error("irq low on link");
    property p_irc; rd_a && paddr == OFS_CMD_GATED && prdata[1:0] != 2'b00 |-> irq; endproperty
    a_irc: assert property (p_irc) else $error("irq low on command");
    cover property ($rose(irq));
    cover property ($fell(irq));
    cover property ($rose(mdio_oe) && !mdio_out);
endmodule
bind mpc_mgmt_ctrl mpc_checker mpc_checker_i (.*);

// file: mpc_mgmt_ctrl.sv
/*
 * Management serial controller with two user transfer channels, two watch
 * channels, acknowledge and link bitmaps, and link/command event registers.
 * Assumes an APB master on pclk and clause 22 PHYs on the serial pins; the
 * data pin is split into input, output and enable for an outside pad.
 */
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps

module mpc_mgmt_ctrl #(
    parameter logic [31:0] VERSION_ID = 32'h0001_0000  // Arbitrary identity value
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mgmt_serial_clock,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe,
    input  wire logic [1:0]  ext_link_input,
    output logic             irq
);
    import mpc_pkg::*;

    // Sticky flag update: hardware set wins over software clear
    function automatic logic [1:0] f_sticky(input logic [1:0] cur,
                                            input logic [1:0] set,
                                            input logic [1:0] clr);
        f_sticky = (cur & ~clr) | set;
    endfunction

    // Offset of a per-channel register
    function automatic logic [11:0] f_chan_ofs(input logic [11:0] base, input int n);
        f_chan_ofs = base + (n[0] ? OFS_CHAN_STEP : 12'h000);
    endfunction

    // Control fields
    logic                enable;
    logic                pre_off;
    logic                fault;
    logic                readback_check_on;
    logic                event_test_set_on;
    logic [15:0]         clkdiv;
    // Bitmaps and events
    logic [31:0]         ack_map;
    logic [31:0]         link_map;
    logic [1:0]          link_change_raw;
    logic [1:0]          cmd_done_raw;
    logic [1:0]          cmd_done_gate_set;
    // Per-channel user transfer and watch configuration
    logic [1:0]          xf_go;
    logic [1:0]          xf_wr;
    logic [1:0]          xf_ack;
    logic [4:0]          xf_reg [2];
    logic [4:0]          xf_phy [2];
    logic [15:0]         xf_data [2];
    logic [4:0]          watched_phy_addr [2];
    logic [1:0]          link_source_select;
    logic [1:0]          link_change_gate;
    // Synchronisers
    logic                mdio_meta;
    logic                mdio_sync;
    logic [1:0]          ext_meta;
    logic [1:0]          ext_sync;
    // Frame engine
    mpc_state_type       state;
    mpc_src_type         cur_src;
    logic                cur_wr;
    logic [4:0]          cur_phy;
    logic [4:0]          cur_reg;
    logic [15:0]         cur_wdata;
    logic [5:0]          bit_cnt;
    logic [15:0]         rd_shift;
    logic                ack_seen;
    logic                poll_sel;
    logic [15:0]         div_cnt;
    logic [1:0]          eff_link_q;

    // Bus decode
    logic                wr_stb;
    logic                rd_setup;
    logic                mapped;
    logic [1:0]          wr_bits;
    logic [31:0]         rd_value;
    // Engine events
    logic                tick_fall;
    logic                tick_rise;
    logic                fault_set;
    logic                done;
    logic                start;
    logic [31:0]         frame_word;
    logic                drv_bit;
    logic                drv_en;
    logic [1:0]          eff_link;
    logic [1:0]          link_chg;
    logic [1:0]          link_gated;
    logic [1:0]          cmd_gated;
    logic [1:0]          cmd_set;
    logic [5:0]          fr_idx;

    assign wr_stb   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wr_bits  = pwdata[1:0];
    assign pready   = 1'b1;  // Zero wait states; no register needs stalling

    // Address decode for the error response
    always_comb begin
        case (paddr)
            OFS_VERSION, OFS_CONTROL, OFS_ACK_MAP, OFS_LINK_MAP,
            OFS_LINK_RAW, OFS_LINK_GATED, OFS_CMD_RAW, OFS_CMD_GATED,
            OFS_GATE_SET, OFS_GATE_CLR, OFS_XFER0, OFS_WATCH0,
            f_chan_ofs(OFS_XFER0, 1), f_chan_ofs(OFS_WATCH0, 1): mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Pin synchronisers; first stages feed only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mdio_meta <= 1'b0;
            mdio_sync <= 1'b0;
            ext_meta  <= 2'b00;
            ext_sync  <= 2'b00;
        end else begin
            mdio_meta <= mdio_in;
            mdio_sync <= mdio_meta;
            ext_meta  <= ext_link_input;
            ext_sync  <= ext_meta;
        end
    end

    // Serial clock divider; zero divider parks the clock low
    assign tick_fall = (clkdiv != 16'h0000) && (div_cnt == clkdiv);
    assign tick_rise = (clkdiv != 16'h0000) && (div_cnt == (clkdiv >> 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt           <= 16'h0000;
            mgmt_serial_clock <= 1'b0;
        end else if (clkdiv == 16'h0000) begin
            div_cnt           <= 16'h0000;
            mgmt_serial_clock <= 1'b0;
        end else begin
            div_cnt           <= (div_cnt >= clkdiv) ? 16'h0000 : div_cnt + 16'h0001;
            mgmt_serial_clock <= (div_cnt > (clkdiv >> 1));
        end
    end

    // Frame content: start, opcode, addresses, turnaround, data
    assign frame_word = {FR_START, cur_wr ? FR_OP_WR : FR_OP_RD, cur_phy, cur_reg,
                         FR_TA_WR, cur_wdata};
    assign fr_idx  = bit_cnt - BIT_FRAME0;
    assign drv_bit = (bit_cnt < BIT_FRAME0) ? 1'b1 : frame_word[5'd31 - fr_idx[4:0]];
    // Reads release the pin from the first turnaround bit onward
    assign drv_en  = (state == ST_FRAME) && (cur_wr || bit_cnt < BIT_TA0);

    // Readback check only at sample points while driving
    // Sample point sits clkdiv>>1 pclk after the drive moves; dividers below 6 read stale bits
    assign fault_set = readback_check_on && (state == ST_FRAME) && tick_rise
                       && mdio_oe && (mdio_sync != mdio_out);
    assign done  = (state == ST_FRAME) && tick_fall && (bit_cnt == BIT_LAST) && !fault_set;
    // New frames only while enabled, so a disable lets the current one finish
    assign start = (state == ST_IDLE) && enable && tick_fall;

    // Frame engine state, channel arbitration and capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_IDLE;
            cur_src   <= SRC_POLL;
            cur_wr    <= 1'b0;
            cur_phy   <= 5'h00;
            cur_reg   <= 5'h00;
            cur_wdata <= 16'h0000;
            bit_cnt   <= 6'd0;
            poll_sel  <= 1'b0;
        end else if (fault_set) begin
            state <= ST_IDLE;
        end else if (start) begin
            state   <= ST_FRAME;
            bit_cnt <= pre_off ? BIT_FRAME0 : 6'd0;
            if (xf_go[0]) begin
                cur_src   <= SRC_USER0;
                cur_wr    <= xf_wr[0];
                cur_phy   <= xf_phy[0];
                cur_reg   <= xf_reg[0];
                cur_wdata <= xf_data[0];
            end else if (xf_go[1]) begin
                cur_src   <= SRC_USER1;
                cur_wr    <= xf_wr[1];
                cur_phy   <= xf_phy[1];
                cur_reg   <= xf_reg[1];
                cur_wdata <= xf_data[1];
            end else begin
                // Idle time polls the watched PHYs' status register in turn
                cur_src   <= SRC_POLL;
                cur_wr    <= 1'b0;
                cur_phy   <= watched_phy_addr[poll_sel];
                cur_reg   <= STATUS_REG;
                cur_wdata <= 16'h0000;
                poll_sel  <= ~poll_sel;
            end
        end else if (state == ST_FRAME && tick_fall) begin
            if (bit_cnt == BIT_LAST) begin
                state <= ST_IDLE;
            end else begin
                bit_cnt <= bit_cnt + 6'd1;
            end
        end
    end

    // Read sampling; PHY pulls the second turnaround bit low to acknowledge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_seen <= 1'b0;
            rd_shift <= 16'h0000;
        end else if (state == ST_FRAME && tick_rise && !cur_wr) begin
            if (bit_cnt == BIT_ACK) begin
                ack_seen <= ~mdio_sync;
            end
            if (bit_cnt >= BIT_DATA0) begin
                rd_shift <= {rd_shift[14:0], mdio_sync};
            end
        end
    end

    // Pin drive registered; held for a whole serial clock period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mdio_out <= 1'b1;
            mdio_oe  <= 1'b0;
        end else begin
            mdio_out <= drv_en ? drv_bit : 1'b1;
            mdio_oe  <= drv_en;
        end
    end

    // Control register; fault set by hardware beats a clearing write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable            <= 1'b0;
            pre_off           <= 1'b0;
            fault             <= 1'b0;
            readback_check_on <= 1'b0;
            event_test_set_on <= 1'b0;
            clkdiv            <= CLKDIV_RESET;
        end else begin
            if (wr_stb && paddr == OFS_CONTROL) begin
                enable            <= pwdata[CTL_ENABLE];
                pre_off           <= pwdata[CTL_PRE_OFF];
                readback_check_on <= pwdata[CTL_CHECK_ON];
                event_test_set_on <= pwdata[CTL_TEST_SET];
                clkdiv            <= pwdata[15:0];
            end
            if (fault_set) begin
                fault <= 1'b1;
            end else if (wr_stb && paddr == OFS_CONTROL && pwdata[CTL_FAULT]) begin
                fault <= 1'b0;
            end
        end
    end

    // Acknowledge and link bitmaps; a completing read overrides an acknowledge clear, and writes leave the link map unchanged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_map  <= 32'h0000_0000;
            link_map <= 32'h0000_0000;
        end else begin
            if (wr_stb && paddr == OFS_ACK_MAP) begin
                ack_map <= ack_map & ~pwdata;
            end
            if (done && !cur_wr) begin
                ack_map[cur_phy] <= ack_seen;
                if (cur_reg == STATUS_REG) begin
                    link_map[cur_phy] <= ack_seen & rd_shift[STATUS_LINK];
                end
            end
        end
    end

    // User transfer channels; writes blocked while go is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xf_go  <= 2'b00;
            xf_wr  <= 2'b00;
            xf_ack <= 2'b00;
            for (int i = 0; i < 2; i++) begin
                xf_reg[i]  <= 5'h00;
                xf_phy[i]  <= 5'h00;
                xf_data[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_stb && paddr == f_chan_ofs(OFS_XFER0, i) && !xf_go[i]) begin
                    xf_go[i]   <= pwdata[XF_GO] & enable;
                    xf_wr[i]   <= pwdata[XF_WR];
                    xf_reg[i]  <= pwdata[XF_REG_LSB +: 5];
                    xf_phy[i]  <= pwdata[XF_PHY_LSB +: 5];
                    xf_data[i] <= pwdata[15:0];
                end
                if (done && cur_src == ((i == 0) ? SRC_USER0 : SRC_USER1)) begin
                    xf_go[i] <= 1'b0;
                    if (!cur_wr) begin
                        xf_ack[i]  <= ack_seen;
                        xf_data[i] <= rd_shift;
                    end
                end
            end
        end
    end

    // Watch channel configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_source_select <= 2'b00;
            link_change_gate   <= 2'b00;
            for (int i = 0; i < 2; i++) begin
                watched_phy_addr[i] <= 5'h00;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_stb && paddr == f_chan_ofs(OFS_WATCH0, i)) begin
                    watched_phy_addr[i]   <= pwdata[4:0];
                    link_source_select[i] <= pwdata[WT_SRC];
                    link_change_gate[i]   <= pwdata[WT_GATE];
                end
            end
        end
    end

    // Effective link per watch channel and its change
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            eff_link[i] = link_source_select[i] ? ext_sync[i]
                                                : link_map[watched_phy_addr[i]];
        end
    end
    assign link_chg   = eff_link ^ eff_link_q;
    assign link_gated = link_change_raw & link_change_gate;
    assign cmd_gated  = cmd_done_raw & cmd_done_gate_set;
    assign cmd_set    = {done && cur_src == SRC_USER1, done && cur_src == SRC_USER0};

    // Event registers; test mode turns written ones into sets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_link_q        <= 2'b00;
            link_change_raw   <= 2'b00;
            cmd_done_raw      <= 2'b00;
            cmd_done_gate_set <= 2'b00;
        end else begin
            eff_link_q <= eff_link;
            link_change_raw <= f_sticky(link_change_raw,
                link_chg
                | ((wr_stb && event_test_set_on && paddr == OFS_LINK_RAW) ? wr_bits : 2'b00)
                | ((wr_stb && event_test_set_on && paddr == OFS_LINK_GATED)
                   ? (wr_bits & link_change_gate) : 2'b00),
                ((wr_stb && paddr == OFS_LINK_RAW) ? wr_bits : 2'b00)
                | ((wr_stb && paddr == OFS_LINK_GATED)
                   ? (wr_bits & link_change_gate) : 2'b00));
            cmd_done_raw <= f_sticky(cmd_done_raw,
                cmd_set
                | ((wr_stb && event_test_set_on && paddr == OFS_CMD_RAW) ? wr_bits : 2'b00)
                | ((wr_stb && event_test_set_on && paddr == OFS_CMD_GATED)
                   ? (wr_bits & cmd_done_gate_set) : 2'b00),
                ((wr_stb && paddr == OFS_CMD_RAW) ? wr_bits : 2'b00)
                | ((wr_stb && paddr == OFS_CMD_GATED)
                   ? (wr_bits & cmd_done_gate_set) : 2'b00));
            if (wr_stb && paddr == OFS_GATE_SET) begin
                cmd_done_gate_set <= cmd_done_gate_set | wr_bits;
            end else if (wr_stb && paddr == OFS_GATE_CLR) begin
                cmd_done_gate_set <= cmd_done_gate_set & ~wr_bits;
            end
        end
    end

    // Interrupt output registered from the gated bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (|link_gated) | (|cmd_gated);
        end
    end

    // Read mux; reserved bits read zero
    always_comb begin
        case (paddr)
            OFS_VERSION:    rd_value = VERSION_ID;
            OFS_CONTROL:    rd_value = {state == ST_IDLE, enable, 1'b0, HIGHEST_CHANNEL,
                                        3'b000, pre_off, fault, readback_check_on,
                                        event_test_set_on, 1'b0, clkdiv};
            OFS_ACK_MAP:    rd_value = ack_map;
            OFS_LINK_MAP:   rd_value = link_map;
            OFS_LINK_RAW:   rd_value = {30'h0, link_change_raw};
            OFS_LINK_GATED: rd_value = {30'h0, link_gated};
            OFS_CMD_RAW:    rd_value = {30'h0, cmd_done_raw};
            OFS_CMD_GATED:  rd_value = {30'h0, cmd_gated};
            OFS_GATE_SET,
            OFS_GATE_CLR:   rd_value = {30'h0, cmd_done_gate_set};
            OFS_XFER0:      rd_value = {xf_go[0], xf_wr[0], xf_ack[0], 3'b000,
                                        xf_reg[0], xf_phy[0], xf_data[0]};
            OFS_WATCH0:     rd_value = {24'h0, link_source_select[0], link_change_gate[0],
                                        1'b0, watched_phy_addr[0]};
            f_chan_ofs(OFS_XFER0, 1):  rd_value = {xf_go[1], xf_wr[1], xf_ack[1], 3'b000,
                                                   xf_reg[1], xf_phy[1], xf_data[1]};
            f_chan_ofs(OFS_WATCH0, 1): rd_value = {24'h0, link_source_select[1],
                                                   link_change_gate[1], 1'b0,
                                                   watched_phy_addr[1]};
            default:        rd_value = 32'h0000_0000;
        endcase
    end

    // Read data and error latched in the setup cycle, valid during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= rd_setup ? rd_value : 32'h0000_0000;
            pslverr <= !mapped;
        end
    end

endmodule

// file: mpc_phy_model.sv
/* Behavioural clause 22 PHY answering reads at one address.
   Assumes the bench resolves the data line with a pull-up. */
`timescale 1ns/1ps
module mpc_phy_model (
    input  wire logic       mdc, mdio, link_up,
    input  wire logic [4:0] addr,
    output logic            oe, d
);
    logic [11:0] sh = 12'hFFF;
    logic        rd = 1'b0;
    int          n  = -1;
    wire  [15:0] dat = {13'h0000, link_up, 2'b00};
    // Sample on the rising edge; a 0 then a 1 opens a frame
    always @(posedge mdc) begin
        if (n < 0) n = (!sh[0] && mdio) ? 0 : -1;
        else n = (n == 29) ? -1 : n + 1;
        sh = {sh[10:0], mdio};
        if (n == 12) rd = sh[11:10] == 2'b10 && sh[9:5] == addr;
    end
    // Turnaround low, then data, moved after the falling edge
    always @(negedge mdc) begin
        oe <= rd && n >= 13;
        d  <= (n >= 14) ? dat[29 - n] : 1'b0;
    end
    initial oe = 1'b0;
endmodule

// file: mpc_pkg.sv
/*
 * Shared constants for the management serial controller: register offsets,
 * field positions, reset values, frame layout and state encodings.
 * Assumes byte addressing on a 32-bit APB bus with one word per register.
 */
package mpc_pkg;

    // Register byte offsets
    localparam logic [11:0] OFS_VERSION    = 12'h000;
    localparam logic [11:0] OFS_CONTROL    = 12'h004;
    localparam logic [11:0] OFS_ACK_MAP    = 12'h008;
    localparam logic [11:0] OFS_LINK_MAP   = 12'h00C;
    localparam logic [11:0] OFS_LINK_RAW   = 12'h010;
    localparam logic [11:0] OFS_LINK_GATED = 12'h014;
    localparam logic [11:0] OFS_CMD_RAW    = 12'h020;
    localparam logic [11:0] OFS_CMD_GATED  = 12'h024;
    localparam logic [11:0] OFS_GATE_SET   = 12'h028;
    localparam logic [11:0] OFS_GATE_CLR   = 12'h02C;
    localparam logic [11:0] OFS_XFER0      = 12'h080;
    localparam logic [11:0] OFS_WATCH0     = 12'h084;
    localparam logic [11:0] OFS_CHAN_STEP  = 12'h008;

    // Control register fields
    localparam int CTL_IDLE      = 31;
    localparam int CTL_ENABLE    = 30;
    localparam int CTL_PRE_OFF   = 20;
    localparam int CTL_FAULT     = 19;
    localparam int CTL_CHECK_ON  = 18;
    localparam int CTL_TEST_SET  = 17;
    localparam logic [4:0]  HIGHEST_CHANNEL = 5'h01;
    localparam logic [15:0] CLKDIV_RESET    = 16'h0255;

    // User transfer channel fields
    localparam int XF_GO      = 31;
    localparam int XF_WR      = 30;
    localparam int XF_REG_LSB = 21;
    localparam int XF_PHY_LSB = 16;

    // Watch channel fields
    localparam int WT_SRC  = 7;
    localparam int WT_GATE = 6;

    // Clause 22 frame layout
    localparam logic [1:0] FR_START    = 2'b01;
    localparam logic [1:0] FR_OP_RD    = 2'b10;
    localparam logic [1:0] FR_OP_WR    = 2'b01;
    localparam logic [1:0] FR_TA_WR    = 2'b10;
    localparam logic [5:0] BIT_FRAME0  = 6'd32;
    localparam logic [5:0] BIT_TA0     = 6'd46;
    localparam logic [5:0] BIT_ACK     = 6'd47;
    localparam logic [5:0] BIT_DATA0   = 6'd48;
    localparam logic [5:0] BIT_LAST    = 6'd63;
    localparam logic [4:0] STATUS_REG  = 5'h01;
    localparam int         STATUS_LINK = 2;

    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_FRAME = 1'b1
    } mpc_state_type;

    typedef enum logic [1:0] {
        SRC_USER0 = 2'b00,
        SRC_USER1 = 2'b01,
        SRC_POLL  = 2'b10
    } mpc_src_type;

endpackage

// file: mpc_tb.sv
/* Self-checking bench: APB master, one PHY model, queued read checks.
   Assumes the design answers each APB access within a few cycles. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
    import mpc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stuck = 0;
    logic [11:0] paddr = 0, ev[2] = '{OFS_LINK_RAW, OFS_CMD_RAW};
    logic [31:0] pwdata = 0, prdata, rv;
    logic [1:0]  ext_link_input = 0;
    logic [4:0]  pa;
    logic [63:0] q[$], e;
    logic        pready, pslverr, mgmt_serial_clock, mdio_out, mdio_oe, irq, po, pd;
    int          n_fail = 0, cmp_count = 0;
    wire         mdio_in = stuck ? 1'b0 : mdio_oe ? mdio_out : po ? pd : 1'b1;
    always #12.5 pclk = ~pclk;
    mpc_mgmt_ctrl mpc_mgmt_ctrl_i (.*);
    mpc_phy_model mpc_phy_model_i (.mdc(mgmt_serial_clock), .mdio(mdio_in), .link_up(1'b1),
                                   .addr(pa), .oe(po), .d(pd));
    task automatic give_verdict;
        $display("Compared %0d, failed %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One APB transfer; a read leaves its masked expectation in the queue
    task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d, m);
        int k = 0;
        if (!w) q.push_back({m, d & m});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        rv = prdata;
        if (k >= 20) begin n_fail++; give_verdict(); end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wt(input logic [11:0] a, input logic [31:0] m, v);
        int k;
        for (k = 0; k < 400; k++) begin
            xf(0, a, 0, 0);
            if ((rv & m) === v) break;
        end
        if (k == 400) begin n_fail++; give_verdict(); end
    endtask
    // Oldest note against each completed read
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && q.size() > 0) begin
            e = q.pop_front();
            if (e[63:32] !== 32'h0) `CHK("prdata", e[31:0], prdata & e[63:32])
        end
    end
    initial begin
        void'($urandom(32'h4fd4_dafe));
        pa = 5'd1 + 5'($urandom % 31);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        ext_link_input <= {1'b1, 1'($urandom)};
        @(posedge pclk);
        xf(0, OFS_CONTROL, 32'h8100_0255, '1);
        xf(0, 12'h030, 0, '1);
        `CHK("pslverr", 1'b1, pslverr)
        xf(1, OFS_WATCH0, 32'h0000_0040 | 32'(pa), 0);
        xf(1, OFS_WATCH0 + OFS_CHAN_STEP, 32'h0000_0080 | 32'(pa), 0);
        xf(1, OFS_CONTROL, 32'h4000_0000, 0);
        xf(1, OFS_CONTROL, 32'h4000_0006, 0);
        wt(OFS_LINK_RAW, 32'h3, 32'h3);
        xf(0, OFS_LINK_GATED, 32'h1, '1);
        xf(0, OFS_LINK_MAP, 32'h1 << pa, '1);
        xf(0, OFS_ACK_MAP, 32'h1 << pa, '1);
        `CHK("irq", 1'b1, irq)
        xf(1, OFS_LINK_RAW, 32'h3, 0);
        xf(0, OFS_LINK_RAW, 32'h0, '1);
        `CHK("irq", 1'b0, irq)
        xf(1, OFS_GATE_SET, 32'h1, 0);
        xf(1, OFS_XFER0, 32'h8020_0000 | 32'(pa) << 16, 0);
        wt(OFS_XFER0, 32'h8000_0000, 0);
        xf(0, OFS_XFER0, 32'h2020_0004 | 32'(pa) << 16, '1);
        xf(0, OFS_CMD_GATED, 32'h1, '1);
        xf(1, OFS_CMD_GATED, 32'h1, 0);
        xf(0, OFS_CMD_RAW, 32'h0, '1);
        xf(1, OFS_CONTROL, 32'h0000_0006, 0);
        wt(OFS_CONTROL, 32'h8000_0000, 32'h8000_0000);
        xf(1, OFS_ACK_MAP, 32'hFFFF_FFFF, 0);
        xf(0, OFS_ACK_MAP, 32'h0, '1);
        xf(1, OFS_LINK_MAP, 32'h0, 0);
        xf(0, OFS_LINK_MAP, 32'h1 << pa, '1);
        xf(1, OFS_CONTROL, 32'h0002_0006, 0);
        foreach (ev[i]) begin xf(1, ev[i], 32'h3, 0); xf(0, ev[i], 32'h3, '1); end
        stuck <= 1'b1;
        xf(1, OFS_CONTROL, 32'h4014_0006, 0);
        wt(OFS_CONTROL, 32'h0008_0000, 32'h0008_0000);
        xf(1, OFS_CONTROL, 32'h4000_0006, 0);
        xf(1, OFS_CONTROL, 32'h4008_0006, 0);
        repeat (40) xf(0, OFS_CONTROL, 32'h4000_0003, 32'h400C_0000);
        stuck <= 1'b0;
        give_verdict();
    end
endmodule
